/* File: src/ledmx_pkg.sv */
// Shared constants and types for the dot-matrix serial register block
package ledmx_pkg;
	localparam int        NUM_DIGITS     = 4;
	localparam int        CHAR_W         = 7;
	// Synchroniser lane positions
	localparam int        PIN_SCL        = 0;
	localparam int        PIN_SDA        = 1;
	localparam int        PIN_STRAP_HI   = 2;
	localparam int        PIN_STRAP_LO   = 3;
	localparam int        PIN_MUX        = 4;
	localparam int        PIN_COUNT      = 5;
	// Slave address
	localparam logic [2:0] SLAVE_FIXED   = 3'h5;
	// Command addresses (bit 7 of the command byte is ignored)
	localparam logic [6:0] CMD_CONFIG    = 7'h04;
	localparam logic [6:0] CMD_FONT      = 7'h05;
	localparam logic [6:0] CMD_HOLD      = 7'h7f;
	localparam logic [1:0] GRP_A         = 2'h1;
	localparam logic [1:0] GRP_B         = 2'h2;
	localparam logic [1:0] GRP_BOTH      = 2'h3;
	// Configuration register fields
	localparam int        CFG_S_BIT      = 0;
	localparam int        CFG_B_BIT      = 2;
	localparam int        CFG_E_BIT      = 3;
	localparam int        CFG_T_BIT      = 4;
	localparam int        CFG_R_BIT      = 5;
	localparam int        CFG_P_BIT      = 7;
	localparam logic [7:0] CFG_STORE_MASK = 8'h0d;
	// Reset values
	localparam logic [7:0] CFG_RESET     = 8'h00;
	localparam logic [7:0] CMD_RESET     = 8'h00;
	localparam logic [7:0] DIGIT_RESET   = 8'h20;
	localparam logic [7:0] FONT_PTR_RESET = 8'h80;
	// Bit counter marks
	localparam logic [3:0] BIT_LAST      = 4'h8;
	localparam logic [3:0] BIT_ACK       = 4'h9;
	// Blink timing in multiplex clock ticks
	localparam int        MUX_REF_HZ     = 4000000;
	localparam int        SLOW_PHASE_MS  = 1000;
	localparam int        FAST_PHASE_MS  = 500;
	localparam int        BLINK_SLOW_TICKS = MUX_REF_HZ / 1000 * SLOW_PHASE_MS;
	localparam int        BLINK_FAST_TICKS = MUX_REF_HZ / 1000 * FAST_PHASE_MS;
	localparam int        BLINK_CNT_W    = 23;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WRITE,
		ST_READ
	} ledmx_state_t;
endpackage : ledmx_pkg

/* File: src/ledmx_blink_timer.sv */
// Blink phase generator counting multiplex clock ticks
`timescale 1ns/10ps
module ledmx_blink_timer
	import ledmx_pkg::*;
#(
	parameter int SLOW_TICKS = BLINK_SLOW_TICKS,
	parameter int FAST_TICKS = BLINK_FAST_TICKS
) (
	input  wire logic clk,     // System clock
	input  wire logic srst,    // Synchronous reset
	input  wire logic tick,    // One multiplex clock edge
	input  wire logic fast,    // Fast blink select
	input  wire logic restart, // Restart blink timing
	output logic      phase    // Current blink plane
);
	logic [BLINK_CNT_W-1:0] cnt_q;
	logic [BLINK_CNT_W-1:0] cnt_d;
	logic                   phase_d;
	logic [BLINK_CNT_W-1:0] lastCnt;

	always_comb begin
		lastCnt = fast ? BLINK_CNT_W'(FAST_TICKS - 1)
			: BLINK_CNT_W'(SLOW_TICKS - 1);
		cnt_d = cnt_q;
		phase_d = phase;
		if (restart) begin
			cnt_d = '0;
			phase_d = 1'b0;
		end else if (tick) begin
			if (cnt_q >= lastCnt) begin
				cnt_d = '0;
				phase_d = ~phase;
			end else begin
				cnt_d = cnt_q + BLINK_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
			phase <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			phase <= phase_d;
		end
	end

	phase_cause_a: assert property (@(posedge clk)
		disable iff (srst) $changed(phase) |-> $past(tick) || $past(restart))
		else $error("blink phase moved without tick or restart");
endmodule : ledmx_blink_timer

/* File: src/ledmx_serial_regs.sv */
// Two-wire slave, command pointer, digit planes and blink control
// Notes on behaviour
// - Write: address, then command byte first
// - Stop after command byte only stores pointer
// - First data byte goes to pointed register
// - Further bytes go onward, pointer advancing
// - Read from pointer, advance after each byte
// - Normal addresses increment after each access
// - Font address: command holds, font pointer steps
// - Top address 7f holds without wrapping
// - Two planes of four digits, both writable
// - Blink off: scan plane A only
// - Blink on: alternate planes each blink phase
// - Low seven bits index character generator
// - Bit seven set inverts digit pixels
// - Blink period from mux clock and rate
// - Reset clears controls, blanks, enters shutdown
// - Config bit 0: shutdown low, run high
// - Writes allowed in shutdown; test overrides
// - Strap pins form address bits 3..0
// - Config: shutdown, rate, enable, clear, restart
// - Upper address bits fixed at 101
// - Bit after address selects read or write
// - Config bit 3 enables blinking globally
`timescale 1ns/10ps
module ledmx_serial_regs
	import ledmx_pkg::*;
#(
	parameter int SLOW_TICKS = BLINK_SLOW_TICKS,
	parameter int FAST_TICKS = BLINK_FAST_TICKS
) (
	input  wire logic                     clk,           // 125 MHz clock
	input  wire logic                     srst,          // Sync reset
	input  wire logic                     sclIn,         // Serial clock pin
	input  wire logic                     sdaIn,         // Serial data pin
	output logic                          sdaOut,        // Data drive level
	output logic                          sdaOe,         // Pulls data low
	input  wire logic                     addrStrapHigh, // Strap, bits 3..2
	input  wire logic                     addrStrapLow,  // Strap, bits 1..0
	input  wire logic                     muxClockIn,    // Multiplex clock
	input  wire logic                     displayTest,   // Test mode level
	output logic [NUM_DIGITS*CHAR_W-1:0]  digitIndex,    // Glyph per digit
	output logic [NUM_DIGITS-1:0]         digitInvert,   // Invert per digit
	output logic                          displayOn,     // Driver enabled
	output logic                          blinkPhase     // Blink clock phase
);
	function automatic logic [7:0] nextPtr(input logic [7:0] c);
		if (c[6:0] == CMD_FONT || c[6:0] == CMD_HOLD) begin
			return c;
		end
		return {c[7], c[6:0] + 7'h01};
	endfunction : nextPtr

	function automatic logic planeHit(input logic [6:0] a,
		input logic [1:0] grp);
		return a[6:5] == grp && a[4:2] == 3'h0;
	endfunction : planeHit

	function automatic logic [1:0] strapCode(input logic hiS,
		input logic sdaLoS, input logic sclLoS);
		if (!hiS) begin
			return 2'h0;
		end else if (!sdaLoS) begin
			return 2'h2;
		end else if (!sclLoS) begin
			return 2'h3;
		end
		return 2'h1;
	endfunction : strapCode

	// Pin synchronisers
	logic [PIN_COUNT-1:0] syncA_q;
	logic [PIN_COUNT-1:0] syncB_q;
	logic [PIN_COUNT-1:0] prev_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			syncA_q <= '1;
			syncB_q <= '1;
			prev_q  <= '1;
		end else begin
			syncA_q <= {muxClockIn, addrStrapLow, addrStrapHigh, sdaIn,
				sclIn};
			syncB_q <= syncA_q;
			prev_q  <= syncB_q;
		end
	end

	logic sclS;
	logic sdaS;
	logic sclRise;
	logic sclFall;
	logic startDet;
	logic stopDet;
	logic muxTick;

	assign sclS     = syncB_q[PIN_SCL];
	assign sdaS     = syncB_q[PIN_SDA];
	assign sclRise  = sclS && !prev_q[PIN_SCL];
	assign sclFall  = !sclS && prev_q[PIN_SCL];
	assign startDet = sclS && prev_q[PIN_SCL] && prev_q[PIN_SDA] && !sdaS;
	assign stopDet  = sclS && prev_q[PIN_SCL] && !prev_q[PIN_SDA] && sdaS;
	assign muxTick  = syncB_q[PIN_MUX] && !prev_q[PIN_MUX];

	// Strap decode: each strap is seen against the bus lines it may follow
	logic [1:0] hiS_q;
	logic [1:0] hiS_d;
	logic [1:0] sdaLoS_q;
	logic [1:0] sdaLoS_d;
	logic [1:0] sclLoS_q;
	logic [1:0] sclLoS_d;
	logic [1:0] strapNow;
	logic [6:0] slaveAddr;

	assign strapNow = {syncB_q[PIN_STRAP_HI], syncB_q[PIN_STRAP_LO]};

	always_comb begin
		hiS_d    = hiS_q;
		sdaLoS_d = sdaLoS_q;
		sclLoS_d = sclLoS_q;
		if (sclS && sdaS) begin
			hiS_d = strapNow;
		end
		if (sclS && !sdaS) begin
			sdaLoS_d = strapNow;
		end
		if (!sclS) begin
			sclLoS_d = strapNow;
		end
		slaveAddr = {SLAVE_FIXED,
			strapCode(hiS_q[1], sdaLoS_q[1], sclLoS_q[1]),
			strapCode(hiS_q[0], sdaLoS_q[0], sclLoS_q[0])};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hiS_q    <= 2'h3;
			sdaLoS_q <= 2'h3;
			sclLoS_q <= 2'h3;
		end else begin
			hiS_q    <= hiS_d;
			sdaLoS_q <= sdaLoS_d;
			sclLoS_q <= sclLoS_d;
		end
	end

	// Protocol engine and register file
	ledmx_state_t state_q;
	ledmx_state_t state_d;
	logic [3:0]   bitCnt_q;
	logic [3:0]   bitCnt_d;
	logic [7:0]   shift_q;
	logic [7:0]   shift_d;
	logic         sdaDrv_q;
	logic         sdaDrv_d;
	logic         rw_q;
	logic         rw_d;
	logic         first_q;
	logic         first_d;
	logic [7:0]   cmd_q;
	logic [7:0]   cmd_d;
	logic [7:0]   font_q;
	logic [7:0]   font_d;
	logic [7:0]   cfg_q;
	logic [7:0]   cfg_d;
	logic [7:0]   planeA_q [NUM_DIGITS];
	logic [7:0]   planeA_d [NUM_DIGITS];
	logic [7:0]   planeB_q [NUM_DIGITS];
	logic [7:0]   planeB_d [NUM_DIGITS];
	logic         wrEn;
	logic         access;
	logic         blinkRestart;
	logic [7:0]   readVal;
	logic [6:0]   ptr;

	assign ptr = cmd_q[6:0];

	always_comb begin
		readVal = 8'h00;
		if (ptr == CMD_CONFIG) begin
			readVal = cfg_q;
			readVal[CFG_P_BIT] = blinkPhase;
		end else if (planeHit(ptr, GRP_A)) begin
			readVal = planeA_q[ptr[1:0]];
		end else if (planeHit(ptr, GRP_B)) begin
			readVal = planeB_q[ptr[1:0]];
		end
	end

	always_comb begin
		state_d  = state_q;
		bitCnt_d = bitCnt_q;
		shift_d  = shift_q;
		sdaDrv_d = sdaDrv_q;
		rw_d     = rw_q;
		first_d  = first_q;
		cmd_d    = cmd_q;
		font_d   = font_q;
		cfg_d    = cfg_q;
		planeA_d = planeA_q;
		planeB_d = planeB_q;
		wrEn     = 1'b0;
		access   = 1'b0;
		blinkRestart = 1'b0;
		if (stopDet) begin
			state_d  = ST_IDLE;
			sdaDrv_d = 1'b0;
		end else if (startDet) begin
			state_d  = ST_ADDR;
			bitCnt_d = 4'h0;
			sdaDrv_d = 1'b0;
		end else begin
			case (state_q)
				ST_ADDR: begin
					if (sclRise && bitCnt_q < BIT_LAST) begin
						shift_d  = {shift_q[6:0], sdaS};
						bitCnt_d = bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == BIT_LAST) begin
						if (shift_q[7:1] == slaveAddr) begin
							sdaDrv_d = 1'b1;
							rw_d     = shift_q[0];
							first_d  = 1'b1;
							bitCnt_d = BIT_ACK;
						end else begin
							state_d = ST_IDLE;
						end
					end else if (sclFall && bitCnt_q == BIT_ACK) begin
						sdaDrv_d = 1'b0;
						bitCnt_d = 4'h0;
						if (rw_q) begin
							state_d  = ST_READ;
							shift_d  = readVal;
							sdaDrv_d = ~readVal[7];
							access   = 1'b1;
						end else begin
							state_d = ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					if (sclRise && bitCnt_q < BIT_LAST) begin
						shift_d  = {shift_q[6:0], sdaS};
						bitCnt_d = bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == BIT_LAST) begin
						sdaDrv_d = 1'b1;
						bitCnt_d = BIT_ACK;
						if (first_q) begin
							cmd_d   = shift_q;
							first_d = 1'b0;
						end else begin
							wrEn   = 1'b1;
							access = 1'b1;
						end
					end else if (sclFall && bitCnt_q == BIT_ACK) begin
						sdaDrv_d = 1'b0;
						bitCnt_d = 4'h0;
					end
				end
				ST_READ: begin
					if (sclRise && bitCnt_q < BIT_LAST) begin
						shift_d  = {shift_q[6:0], 1'b0};
						bitCnt_d = bitCnt_q + 4'h1;
					end else if (sclRise && bitCnt_q == BIT_LAST) begin
						if (sdaS) begin
							state_d = ST_IDLE;
						end else begin
							bitCnt_d = BIT_ACK;
						end
					end else if (sclFall && bitCnt_q == BIT_LAST) begin
						sdaDrv_d = 1'b0;
					end else if (sclFall && bitCnt_q == BIT_ACK) begin
						bitCnt_d = 4'h0;
						shift_d  = readVal;
						sdaDrv_d = ~readVal[7];
						access   = 1'b1;
					end else if (sclFall) begin
						sdaDrv_d = ~shift_q[7];
					end
				end
				ST_IDLE: begin
					sdaDrv_d = 1'b0;
				end
				default: begin
					state_d  = ST_IDLE;
					sdaDrv_d = 1'b0;
				end
			endcase
		end
		if (wrEn) begin
			if (ptr == CMD_CONFIG) begin
				cfg_d = shift_q & CFG_STORE_MASK;
				if (shift_q[CFG_R_BIT]) begin
					for (int i = 0; i < NUM_DIGITS; i++) begin
						planeA_d[i] = DIGIT_RESET;
						planeB_d[i] = DIGIT_RESET;
					end
				end
				blinkRestart = shift_q[CFG_T_BIT];
			end
			if (planeHit(ptr, GRP_A) || planeHit(ptr, GRP_BOTH)) begin
				planeA_d[ptr[1:0]] = shift_q;
			end
			if (planeHit(ptr, GRP_B) || planeHit(ptr, GRP_BOTH)) begin
				planeB_d[ptr[1:0]] = shift_q;
			end
		end
		if (access) begin
			cmd_d = nextPtr(cmd_q);
			if (ptr == CMD_FONT) begin
				font_d = {1'b1, font_q[6:0] + 7'h01};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q  <= ST_IDLE;
			bitCnt_q <= 4'h0;
			shift_q  <= 8'h00;
			sdaDrv_q <= 1'b0;
			rw_q     <= 1'b0;
			first_q  <= 1'b0;
			cmd_q    <= CMD_RESET;
			font_q   <= FONT_PTR_RESET;
			cfg_q    <= CFG_RESET;
			for (int i = 0; i < NUM_DIGITS; i++) begin
				planeA_q[i] <= DIGIT_RESET;
				planeB_q[i] <= DIGIT_RESET;
			end
		end else begin
			state_q  <= state_d;
			bitCnt_q <= bitCnt_d;
			shift_q  <= shift_d;
			sdaDrv_q <= sdaDrv_d;
			rw_q     <= rw_d;
			first_q  <= first_d;
			cmd_q    <= cmd_d;
			font_q   <= font_d;
			cfg_q    <= cfg_d;
			planeA_q <= planeA_d;
			planeB_q <= planeB_d;
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe  = sdaDrv_q;

	ledmx_blink_timer #(
		.SLOW_TICKS (SLOW_TICKS),
		.FAST_TICKS (FAST_TICKS)
	) blinkTimer (
		.clk     (clk),
		.srst    (srst),
		.tick    (muxTick),
		.fast    (cfg_q[CFG_B_BIT]),
		.restart (blinkRestart),
		.phase   (blinkPhase)
	);

	// Display data: plane choice, glyph index and inversion per digit
	logic                         usePlaneB;
	logic [NUM_DIGITS*CHAR_W-1:0] index_d;
	logic [NUM_DIGITS-1:0]        invert_d;
	logic                         on_d;

	assign usePlaneB = cfg_q[CFG_E_BIT] && blinkPhase;
	assign on_d      = cfg_q[CFG_S_BIT] || displayTest;

	for (genvar g = 0; g < NUM_DIGITS; g++) begin : gDigit
		logic [7:0] shown;
		assign shown = usePlaneB ? planeB_q[g] : planeA_q[g];
		assign index_d[g*CHAR_W +: CHAR_W] = shown[6:0];
		assign invert_d[g] = shown[7];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			digitIndex  <= {NUM_DIGITS{DIGIT_RESET[6:0]}};
			digitInvert <= '0;
			displayOn   <= 1'b0;
		end else begin
			digitIndex  <= index_d;
			digitInvert <= invert_d;
			displayOn   <= on_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	addr_ack_a: assert property (state_q == ST_ADDR && sclFall
		&& bitCnt_q == BIT_LAST && shift_q[7:1] == slaveAddr
		|=> sdaOe && bitCnt_q == BIT_ACK)
		else $error("address match not acknowledged");
	stop_release_a: assert property (stopDet
		|=> !sdaOe && state_q == ST_IDLE)
		else $error("stop did not release the bus");
	cmd_store_a: assert property (state_q == ST_WRITE && sclFall
		&& bitCnt_q == BIT_LAST && first_q
		|=> cmd_q == $past(shift_q) && !first_q)
		else $error("command byte not stored");
	ptr_step_a: assert property (access && ptr != CMD_FONT
		&& ptr != CMD_HOLD |=> cmd_q[6:0] == $past(ptr) + 7'h01)
		else $error("pointer did not increment");
	ptr_hold_a: assert property (access && ptr == CMD_HOLD
		|=> cmd_q[6:0] == CMD_HOLD)
		else $error("pointer moved off top address");
	font_step_a: assert property (access && ptr == CMD_FONT
		|=> ptr == CMD_FONT && font_q[6:0] == $past(font_q[6:0]) + 7'h01)
		else $error("font pointer did not step");
	read_load_a: assert property (state_q == ST_ADDR && sclFall
		&& bitCnt_q == BIT_ACK && rw_q
		|=> shift_q == $past(readVal) && sdaOe == !shift_q[7])
		else $error("first read byte not loaded");
	plane_a_only_a: assert property (!cfg_q[CFG_E_BIT]
		|=> digitIndex[CHAR_W-1:0] == $past(planeA_q[0][6:0]))
		else $error("plane B shown with blink off");
	invert_a: assert property (1'b1
		|=> digitInvert[0] == $past((cfg_q[CFG_E_BIT] && blinkPhase)
		? planeB_q[0][7] : planeA_q[0][7]))
		else $error("digit inversion wrong");
	shutdown_a: assert property (!cfg_q[CFG_S_BIT] && !displayTest
		|=> !displayOn)
		else $error("display on during shutdown");

	write_cov: cover property (wrEn ##[1:300] stopDet);
	read_nack_cov: cover property (state_q == ST_READ && sclRise
		&& bitCnt_q == BIT_LAST && sdaS);
	blink_cov: cover property (cfg_q[CFG_E_BIT] && $rose(blinkPhase));
	clear_cov: cover property (wrEn && ptr == CMD_CONFIG
		&& shift_q[CFG_R_BIT]);
endmodule : ledmx_serial_regs

/* File: bench/ledmx_bus_master.sv */
// Two-wire bus master model that drives the serial clock and data line
`timescale 1ns/10ps
module ledmx_bus_master (
	input  wire logic clk,     // Bench clock
	input  wire logic sdaWire, // Resolved data line
	output logic      sclOut,  // Serial clock drive
	output logic      sdaLow   // High pulls data low
);
	localparam int QTR = 16;
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	// Clock moves only inside frames and rests high between them
	task automatic bitIo(input logic b, output logic s);
		sdaLow <= ~b;
		hold(QTR);
		sclOut <= 1'b1;
		hold(2 * QTR);
		s = sdaWire;
		sclOut <= 1'b0;
		hold(QTR);
	endtask : bitIo
	// Also serves as repeated start from a low clock
	task automatic start();
		sdaLow <= 1'b0;
		hold(QTR);
		sclOut <= 1'b1;
		hold(2 * QTR);
		sdaLow <= 1'b1;
		hold(2 * QTR);
		sclOut <= 1'b0;
		hold(QTR);
	endtask : start
	task automatic stop();
		sdaLow <= 1'b1;
		hold(QTR);
		sclOut <= 1'b1;
		hold(2 * QTR);
		sdaLow <= 1'b0;
		hold(2 * QTR);
	endtask : stop
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(b[i], s);
		end
		bitIo(1'b1, s);
		ack = (s === 1'b0);
	endtask : sendByte
	task automatic recvByte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(1'b1, d[i]);
		end
		bitIo(nack, s);
	endtask : recvByte
endmodule : ledmx_bus_master

/* File: bench/tb.sv */
// Self-checking bench for the serial register block
`timescale 1ns/10ps
module tb
	import ledmx_pkg::*;
;
	localparam int SLOW = 8;
	localparam int FAST = 4;
	localparam logic [6:0] DEV_ADDR = {SLAVE_FIXED, 4'hb};
	logic                         clk;
	logic                         srst;
	logic                         muxClk;
	logic                         displayTest;
	logic                         sdaOut;
	logic                         sdaOe;
	logic                         sclWire;
	logic                         mSdaLow;
	logic                         sdaWire;
	logic [NUM_DIGITS*CHAR_W-1:0] digitIndex;
	logic [NUM_DIGITS-1:0]        digitInvert;
	logic                         displayOn;
	logic                         blinkPhase;
	int                           miscompares = 0;
	int                           compares = 0;
	int                           n;
	logic                         bad;
	// Pull-up wire: low when either party pulls it
	assign sdaWire = !(sdaOe && !sdaOut) && !mSdaLow;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		muxClk = 1'b0;
		#3.3;
		forever #62.5 muxClk = ~muxClk;
	end
	ledmx_bus_master mst (.clk(clk), .sdaWire(sdaWire), .sclOut(sclWire),
		.sdaLow(mSdaLow));
	// Straps on data and clock lines give address bits 1011
	ledmx_serial_regs #(.SLOW_TICKS(SLOW), .FAST_TICKS(FAST)) dut (
		.clk(clk), .srst(srst), .sclIn(sclWire), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapHigh(sdaWire),
		.addrStrapLow(sclWire), .muxClockIn(muxClk),
		.displayTest(displayTest), .digitIndex(digitIndex),
		.digitInvert(digitInvert), .displayOn(displayOn),
		.blinkPhase(blinkPhase));
	task automatic end_sim();
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic wrRegs(input logic [7:0] cmd, input logic [7:0] d[$]);
		logic ack;
		mst.start();
		mst.sendByte({DEV_ADDR, 1'b0}, ack);
		chk(ack, 1, "address ack");
		mst.sendByte(cmd, ack);
		chk(ack, 1, "command ack");
		foreach (d[i]) begin
			mst.sendByte(d[i], ack);
			chk(ack, 1, "data ack");
		end
		mst.stop();
	endtask : wrRegs
	// Pointer set by a command-only write, then read with nack at the end
	task automatic rdChk(input logic [7:0] cmd, input logic [7:0] e[$],
		input logic rstart);
		logic       ack;
		logic [7:0] got;
		mst.start();
		mst.sendByte({DEV_ADDR, 1'b0}, ack);
		mst.sendByte(cmd, ack);
		if (!rstart) begin
			mst.stop();
		end
		mst.start();
		mst.sendByte({DEV_ADDR, 1'b1}, ack);
		chk(ack, 1, "read address ack");
		foreach (e[i]) begin
			mst.recvByte(i == e.size() - 1, got);
			chk(got, e[i], "read byte");
		end
		mst.stop();
		chk(sdaOe, 0, "data line released");
	endtask : rdChk
	task automatic flip(output int cnt);
		logic p;
		p = blinkPhase;
		cnt = 0;
		while (blinkPhase === p && cnt < 1000) begin
			@(posedge clk);
			cnt++;
		end
		chk(cnt < 1000, 1, "blink phase stuck");
	endtask : flip
	task automatic period(input int ticks);
		int e;
		e = ticks * 125 / 8;
		flip(n);
		flip(n);
		flip(n);
		chk(n >= e - 4 && n <= e + 4, 1, "blink period");
	endtask : period
	task automatic chkBlank();
		for (int d = 0; d < NUM_DIGITS; d++) begin
			chk(digitIndex[d*CHAR_W +: CHAR_W], DIGIT_RESET, "blank");
		end
		chk(digitInvert, 0, "no inversion");
	endtask : chkBlank
	initial begin
		srst = 1'b1;
		displayTest = 1'b0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		chkBlank();
		chk({displayOn, blinkPhase}, 0, "shutdown at reset");
		displayTest <= 1'b1;
		repeat (6) @(posedge clk);
		chk(displayOn, 1, "test overrides shutdown");
		displayTest <= 1'b0;
		mst.start();
		mst.sendByte({SLAVE_FIXED, 4'h0, 1'b0}, bad);
		mst.stop();
		chk(bad, 0, "foreign address ignored");
		rdChk(8'h20, '{8'h20, 8'h20, 8'h20, 8'h20, 8'h00}, 1'b0);
		wrRegs(8'h20, '{8'h41, 8'h42, 8'hc3, 8'h44});
		chk(digitIndex, {7'h44, 7'h43, 7'h42, 7'h41}, "glyphs");
		chk(digitInvert, 4'h4, "inverted digit");
		rdChk(8'ha0, '{8'h41, 8'h42, 8'hc3, 8'h44}, 1'b1);
		wrRegs(8'h03, '{8'haa, 8'h01});
		repeat (4) @(posedge clk);
		chk(displayOn, 1, "normal operation");
		wrRegs(8'h7f, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		chk(displayOn, 1, "top address holds");
		wrRegs(8'h05, '{8'h00, 8'h00});
		wrRegs(8'h40, '{8'h55});
		wrRegs(8'h61, '{8'h33});
		bad = 1'b0;
		repeat (300) begin
			@(posedge clk);
			if (digitIndex[CHAR_W-1:0] !== 7'h41)
				bad = 1'b1;
		end
		chk(bad, 0, "plane A only while blink off");
		chk(digitIndex[2*CHAR_W-1:CHAR_W], 7'h33, "both planes");
		wrRegs({1'b0, CMD_CONFIG}, '{8'h09});
		flip(n);
		if (blinkPhase !== 1'b1)
			flip(n);
		repeat (2) @(posedge clk);
		chk(digitIndex[CHAR_W-1:0], 7'h55, "plane B phase");
		chk(digitIndex[2*CHAR_W-1:CHAR_W], 7'h33, "plane B copy");
		flip(n);
		repeat (2) @(posedge clk);
		chk(digitIndex[CHAR_W-1:0], 7'h41, "plane A phase");
		period(SLOW);
		wrRegs({1'b0, CMD_CONFIG}, '{8'h0d});
		period(FAST);
		// Restart lands near the data byte's last fall; two slow phases later
		wrRegs({1'b0, CMD_CONFIG}, '{8'h19});
		flip(n);
		chk(n >= 74 && n <= 98, 1, "blink restart timing");
		chk(blinkPhase, 0, "phase after restart");
		wrRegs({1'b0, CMD_CONFIG}, '{8'h21});
		repeat (4) @(posedge clk);
		chkBlank();
		end_sim();
	end
	initial begin
		repeat (80000) @(posedge clk);
		miscompares++;
		$display("FAIL %0t watchdog expired", $time);
		end_sim();
	end
endmodule : tb
